// file: core/itm_defs.svh
// constants of the 16-bit interval timer
// Function
// - the block holds a 16-bit counter that runs as a free-running interval timer or event counter.
// - the counter has exactly four modes: timer, gated timer, synchronous and asynchronous counter.
// - the asynchronous counter mode counts external clock events with no synchroniser in the path.
// - with synchronisation selected the prescaled external clock is synchronised after the prescaler.
// - timer and gated timer modes count the instruction-cycle clock.
// - both counter modes count the external clock pin.
// - bit 1 of the control word selects the clock source, 1 for external and 0 for internal.
// - bit 2 of the control word selects synchronisation of the external clock.
// - bit 6 of the control word enables gated accumulation.
// - with the internal clock, gating 0 gives timer mode and 1 gated timer mode, sync is ignored.
// - with the external clock and sync 1 the block is a synchronous counter, gating is ignored.
// - with the external clock and sync 0 the block is an asynchronous counter, gating is ignored.
`ifndef ITM_DEFS_SVH
`define ITM_DEFS_SVH
`define ITM_CNT_W    16
`define ITM_CTL_W    16
`define ITM_PRE_W    8
`define ITM_CS_BIT   1
`define ITM_SYNC_BIT 2
`define ITM_GATE_BIT 6
`define ITM_CNT_RST  16'h0000
`define ITM_CNT_ONE  16'h0001
`define ITM_PRE_RST  8'h00
`define ITM_PRE_ONE  8'h01
`endif

// file: core/itm_pkg.sv
// types of the 16-bit interval timer
package itm_pkg;
  typedef enum logic [1:0] {
    M_TIMER,
    M_GATED,
    M_SYNC,
    M_ASYNC
  } itm_mode_type;
endpackage

// file: core/itm_presc_if.sv
// link between the timer core and its prescaler
`timescale 1ns/1ns
`include "itm_defs.svh"
interface itm_presc_if;
  logic                  tick;
  logic                  clear;
  logic [`ITM_PRE_W-1:0] ratio;
  logic                  toggle;
  modport core (output tick, output clear, output ratio, input toggle);
  modport presc (input tick, input clear, input ratio, output toggle);
endinterface

// file: core/itm_prescaler.sv
// event prescaler: flips its toggle once every ratio+1 input ticks
`timescale 1ns/1ns
`include "itm_defs.svh"
module itm_prescaler (
  // clock and reset
  input  logic        i_clk,
  input  logic        i_rst_b,
  // core side
  itm_presc_if.presc  pif
);
  logic [`ITM_PRE_W-1:0] cnt_reg;
  logic [`ITM_PRE_W-1:0] cnt_next;
  logic                  tog_reg;
  logic                  tog_next;

  // a toggle, not a pulse, so a slow receiver behind a synchroniser never misses it
  always_comb begin
    cnt_next = cnt_reg;
    tog_next = tog_reg;
    if (pif.clear) begin
      cnt_next = `ITM_PRE_RST;
    end else if (pif.tick) begin
      // a ratio lowered under the running count ends the cycle at once, no 256-event stall
      if (cnt_reg >= pif.ratio) begin
        cnt_next = `ITM_PRE_RST;
        tog_next = ~tog_reg;
      end else begin
        cnt_next = cnt_reg + `ITM_PRE_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= `ITM_PRE_RST;
      tog_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tog_reg <= tog_next;
    end
  end

  assign pif.toggle = tog_reg;

  a_toggle_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pif.tick |=> $stable(tog_reg))
    else $error("prescaler toggled without an input tick");
endmodule

// file: core/itm_timer.sv
// 16-bit interval timer with timer, gated, sync and async counter modes
`timescale 1ns/1ns
`include "itm_defs.svh"
module itm_timer (
  // clock and reset
  input  logic                  i_clk,
  input  logic                  i_rst_b,
  // control
  input  logic                  i_timer_on,
  input  logic [`ITM_CTL_W-1:0] i_first_timer_control,
  input  logic [`ITM_PRE_W-1:0] i_prescale_ratio,
  input  logic [`ITM_CNT_W-1:0] i_period,
  input  logic                  i_flag_clear,
  // pin
  input  logic                  i_first_timer_ext_clock_pin,
  // status
  output logic [`ITM_CNT_W-1:0] o_count,
  output logic                  o_period_flag,
  output logic [1:0]            o_mode
);
  itm_presc_if pif ();

  itm_pkg::itm_mode_type mode_reg;
  itm_pkg::itm_mode_type mode_next;
  logic                  pin_q_reg;
  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  sync3_reg;
  logic                  tog_q_reg;
  logic [`ITM_CNT_W-1:0] count_reg;
  logic [`ITM_CNT_W-1:0] count_next;
  logic                  flag_reg;
  logic                  flag_next;
  logic                  ctl_cs;
  logic                  ctl_sync;
  logic                  ctl_gate;
  logic                  pin_rise;
  logic                  async_edge;
  logic                  sync_edge;
  logic                  count_tick;
  logic                  wrap;

  assign ctl_cs   = i_first_timer_control[`ITM_CS_BIT];
  assign ctl_sync = i_first_timer_control[`ITM_SYNC_BIT];
  assign ctl_gate = i_first_timer_control[`ITM_GATE_BIT];

  // mode decode
  always_comb begin
    if (!ctl_cs) begin
      mode_next = ctl_gate ? itm_pkg::M_GATED : itm_pkg::M_TIMER;
    end else if (ctl_sync) begin
      mode_next = itm_pkg::M_SYNC;
    end else begin
      mode_next = itm_pkg::M_ASYNC;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg <= itm_pkg::M_TIMER;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // prescaler input selection
  assign pin_rise = i_first_timer_ext_clock_pin & ~pin_q_reg;

  always_comb begin
    pif.tick = 1'b0;
    if (i_timer_on) begin
      unique case (mode_reg)
        itm_pkg::M_TIMER: pif.tick = 1'b1;
        itm_pkg::M_GATED: pif.tick = i_first_timer_ext_clock_pin;
        itm_pkg::M_SYNC:  pif.tick = pin_rise;
        itm_pkg::M_ASYNC: pif.tick = pin_rise;
      endcase
    end
  end

  // a stopped timer restarts its prescaler from zero
  assign pif.clear = ~i_timer_on;
  assign pif.ratio = i_prescale_ratio;

  itm_prescaler u_presc (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .pif     (pif)
  );

  // edge and synchroniser registers; the sync path costs two cycles of latency
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q_reg <= 1'b0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      tog_q_reg <= 1'b0;
    end else begin
      pin_q_reg <= i_first_timer_ext_clock_pin;
      sync1_reg <= pif.toggle;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      tog_q_reg <= pif.toggle;
    end
  end

  assign async_edge = pif.toggle ^ tog_q_reg;
  assign sync_edge  = sync2_reg ^ sync3_reg;

  assign count_tick = i_timer_on &
                      ((mode_reg == itm_pkg::M_SYNC) ? sync_edge : async_edge);
  assign wrap       = count_tick & (count_reg == i_period);

  // counter and period flag; a new wrap beats a clear in the same cycle
  always_comb begin
    count_next = count_reg;
    if (wrap) begin
      count_next = `ITM_CNT_RST;
    end else if (count_tick) begin
      count_next = count_reg + `ITM_CNT_ONE;
    end
    flag_next = wrap | (flag_reg & ~i_flag_clear);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg <= `ITM_CNT_RST;
      flag_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      flag_reg  <= flag_next;
    end
  end

  assign o_count       = count_reg;
  assign o_period_flag = flag_reg;
  assign o_mode        = mode_reg;

  a_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (count_tick && count_reg != i_period) |=> count_reg == $past(count_reg) + `ITM_CNT_ONE)
    else $error("counter did not step by one");

  a_count_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !count_tick |=> $stable(count_reg))
    else $error("counter moved without a count tick");

  a_wrap_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (count_tick && count_reg == i_period) |=> (count_reg == `ITM_CNT_RST) && flag_reg)
    else $error("period match did not wrap and flag");

  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (flag_reg && !i_flag_clear) |=> flag_reg)
    else $error("period flag dropped without a clear");

  a_mode_timer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!ctl_cs && !ctl_gate) |=> mode_reg == itm_pkg::M_TIMER)
    else $error("internal clock without gating is not timer mode");

  a_mode_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!ctl_cs && ctl_gate) |=> mode_reg == itm_pkg::M_GATED)
    else $error("internal clock with gating is not gated mode");

  a_mode_sync: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctl_cs && ctl_sync) |=> mode_reg == itm_pkg::M_SYNC)
    else $error("external clock with sync is not sync counter mode");

  a_mode_async: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctl_cs && !ctl_sync) |=> mode_reg == itm_pkg::M_ASYNC)
    else $error("external clock without sync is not async counter mode");

  a_timer_source: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_timer_on && mode_reg == itm_pkg::M_TIMER) |-> pif.tick)
    else $error("timer mode missed an instruction cycle");

  a_gate_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (mode_reg == itm_pkg::M_GATED && !i_first_timer_ext_clock_pin) |-> !pif.tick)
    else $error("gated timer counted while the gate was low");

  a_pin_source: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_timer_on && (mode_reg == itm_pkg::M_SYNC || mode_reg == itm_pkg::M_ASYNC))
      |-> pif.tick == pin_rise)
    else $error("counter mode not fed by the pin edge");

  a_async_direct: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_timer_on && mode_reg == itm_pkg::M_ASYNC && $changed(pif.toggle)) |-> count_tick)
    else $error("async counter delayed a prescaled edge");

  a_sync_latency: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (mode_reg == itm_pkg::M_SYNC && $changed(pif.toggle))
      ##2 (i_timer_on && mode_reg == itm_pkg::M_SYNC) |-> count_tick)
    else $error("sync counter edge not seen two cycles later");

  a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wrap && i_flag_clear) |=> flag_reg)
    else $error("period flag clear beat a wrap in the same cycle");

  a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (flag_reg && i_flag_clear && !wrap) |=> !flag_reg)
    else $error("period flag survived a clear");

  a_flag_cause: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(flag_reg) |-> $past(wrap))
    else $error("period flag set without a wrap");

  a_stop_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_timer_on |=> $stable(count_reg))
    else $error("stopped timer changed its count");

  a_gate_high: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_timer_on && mode_reg == itm_pkg::M_GATED && i_first_timer_ext_clock_pin)
      |-> pif.tick)
    else $error("gated timer missed a cycle with the gate high");

  a_sync_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_timer_on && mode_reg == itm_pkg::M_SYNC && sync2_reg == sync3_reg)
      |-> !count_tick)
    else $error("sync counter counted without a synchronised edge");

  a_async_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_timer_on && mode_reg == itm_pkg::M_ASYNC && $stable(pif.toggle))
      |-> !count_tick)
    else $error("async counter counted without a prescaled edge");
endmodule

// file: dv/itm_ext_src.sv
// external clock and gate source driving the timer pin
`timescale 1ns/1ns
module itm_ext_src (
  // clock
  input  wire logic       i_clk,
  // control from the bench
  input  wire logic       i_run,
  input  wire logic       i_level,
  input  wire logic [3:0] i_half,
  // pin
  output logic            o_pin
);
  logic       run_q;
  logic       lvl_q;
  logic [3:0] half_q;
  int         cnt;
  initial begin
    o_pin = 1'b0;
    cnt = 0;
  end
  // the clock stands at the gate level between bursts, it never runs free
  // bench inputs are taken at the edge and acted on 5 ns later: a fixed one-cycle lag
  // that keeps the model clear of the bench's own writes in the same time step
  always @(posedge i_clk) begin
    run_q = i_run;
    lvl_q = i_level;
    half_q = i_half;
    #5;
    if (!run_q) begin
      o_pin = lvl_q;
      cnt = 0;
    end else if (cnt + 1 >= int'(half_q)) begin
      o_pin = ~o_pin;
      cnt = 0;
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule

// file: dv/testbench.sv
// self-checking bench of the interval timer
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        rst_b;
  logic        on;
  logic [15:0] ctl;
  logic [7:0]  ratio;
  logic [15:0] period;
  logic        fclr;
  logic        pin;
  logic [15:0] count;
  logic        flag;
  logic [1:0]  mode;
  logic        s_run;
  logic        s_lvl;
  logic [3:0]  s_half;
  logic [15:0] c0;
  int          mismatches;
  int          num_checks;
  int          n;
  itm_timer dut (.i_clk(clk), .i_rst_b(rst_b), .i_timer_on(on), .i_first_timer_control(ctl),
    .i_prescale_ratio(ratio), .i_period(period), .i_flag_clear(fclr),
    .i_first_timer_ext_clock_pin(pin), .o_count(count), .o_period_flag(flag), .o_mode(mode));
  itm_ext_src src (.i_clk(clk), .i_run(s_run), .i_level(s_lvl), .i_half(s_half), .o_pin(pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #5;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] exp_mode(input logic [15:0] c);
    if (!c[1]) return c[6] ? 16'h0001 : 16'h0000;
    return c[2] ? 16'h0002 : 16'h0003;
  endfunction
  // steady-state delta, so pipeline lag and prescaler phase drop out
  task automatic measure(input int cyc, input logic [15:0] exp);
    c0 = count;
    tick(cyc);
    chk_val(count - c0, exp);
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    tick(3);
    rst_b = 1'b1;
  endtask
  initial begin
    {on, ctl, ratio, fclr, s_run, s_lvl} = '0;
    period = 16'hFFFF;
    s_half = 4'h1;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'h993D));
    do_reset;
    chk_val(count, 16'h0000);
    chk_bit(flag, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ctl = (16'($urandom()) & 16'hFFB9) | {9'h000, i[2], 3'h0, i[1:0], 1'b0};
      tick(2);
      chk_val({14'h0000, mode}, exp_mode(ctl));
    end
    $display("mode decode done");
    on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ratio = 8'($urandom_range(3));
      ctl = {9'h000, k[1], 3'h0, 1'($urandom()), 2'b00};
      s_lvl = k[0];
      tick(12);
      measure(5 * (ratio + 1), (k == 2) ? 16'h0000 : 16'h0005);
    end
    $display("timer modes done");
    for (int k = 0; k < 4; k++) begin
      ratio = 8'($urandom_range(2));
      s_half = 4'($urandom_range(3, 1));
      ctl = {9'h000, 1'($urandom()), 3'h0, k[0], 2'b10};
      s_run = k[1];
      tick(60);
      measure(8 * s_half * (ratio + 1), k[1] ? 16'h0004 : 16'h0000);
    end
    $display("counter modes done");
    s_run = 1'b0;
    s_lvl = 1'b0;
    ratio = 8'h00;
    for (int s = 0; s < 2; s++) begin
      ctl = {13'h0000, s[0], 2'b10};
      tick(10);
      c0 = count;
      s_lvl = 1'b1;
      tick(1);
      s_lvl = 1'b0;
      tick(1 + 2 * s);
      chk_val(count, c0);
      tick(1);
      chk_val(count, c0 + 16'h0001);
    end
    $display("latency done");
    on = 1'b0;
    ctl = 16'h0000;
    period = 16'($urandom_range(12, 2));
    do_reset;
    on = 1'b1;
    n = 0;
    while (flag !== 1'b1 && n < 40) begin
      c0 = count;
      tick(1);
      n++;
    end
    if (flag !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: wait for flag ran out", $time);
    end else begin
      chk_val(c0, period);
      chk_val(count, 16'h0000);
      tick(1);
      chk_bit(flag, 1'b1);
      on = 1'b0;
      fclr = 1'b1;
      tick(1);
      fclr = 1'b0;
      tick(1);
      chk_bit(flag, 1'b0);
    end
    $display("wrap done");
    test_done;
  end
endmodule
